// >>> verilog/ptp_ctrl_pkg.sv
/*
  constants for the ptp address-fix, output clock and timestamper source control block:
  register offsets, field positions, reset values, codes and timing figures.
  assumes a 5-bit management register address and 16-bit register data.
*/
`default_nettype none
package ptp_ctrl_pkg;
    localparam int           REG_ADDR_W          = 5;
    localparam int           REG_DATA_W          = 16;
    localparam logic [4:0]   ADDR_CLOCK_OUT_CTRL = 5'h11;
    localparam logic [4:0]   ADDR_STAMPER_SRC    = 5'h12;
    localparam logic [4:0]   ADDR_FIRST_RATIO    = 5'h14;
    localparam logic [15:0]  RESET_CLOCK_OUT     = 16'h0000;
    localparam logic [15:0]  RESET_STAMPER_SRC   = 16'h0000;
    localparam logic [15:0]  RESET_FIRST_RATIO   = 16'h0000;
    // address-fix enables occupy bits 15 down to 9
    localparam int           FIX_EN_LSB          = 9;
    localparam int           FIX_EN_W            = 7;
    localparam int           INVERT_BIT          = 8;
    localparam int           CLK_RATIO_LSB       = 0;
    localparam int           CLK_RATIO_W         = 8;
    localparam int           C_EDGE_LSB          = 14;
    localparam int           C_SRC_LSB           = 12;
    localparam int           B_EDGE_LSB          = 10;
    localparam int           B_SRC_LSB           = 8;
    localparam int           A_EDGE_LSB          = 6;
    localparam int           A_SRC_LSB           = 4;
    localparam int           A_SECOND_LSB        = 0;
    localparam logic [15:0]  STAMPER_SRC_WR_MASK = 16'hfff7;
    localparam logic [1:0]   EDGE_NONE           = 2'h0;
    localparam logic [1:0]   EDGE_RISE           = 2'h1;
    localparam logic [1:0]   EDGE_FALL           = 2'h2;
    localparam logic [1:0]   EDGE_BOTH           = 2'h3;
    localparam logic [1:0]   SRC_INTERNAL        = 2'h0;
    localparam logic [15:0]  SECOND_RATIO_TABLE [8] = '{16'h0001, 16'h000a, 16'h0064, 16'h03e8,
                                                      16'h0002, 16'h0050, 16'h0320, 16'h1f40};
    // timing: output clock reference and system clock rates
    localparam int           SYS_CLK_MHZ         = 250;
    localparam int           CLKO_REF_MHZ        = 125;
    localparam int           CLKO_HALF_STEP      = (SYS_CLK_MHZ / CLKO_REF_MHZ) / 2;
endpackage
`default_nettype wire

// >>> verilog/level_divider.sv
/*
  divides the edge rate of a level signal by a programmable ratio.
  assumes sigIn is already on ref_clk; ratio of 0 or 1 passes the signal straight through.
*/
`timescale 1ns/1ps
`default_nettype none
module level_divider #(
    parameter int W = 16
) (
    // clock and reset
    input  wire logic         ref_clk,
    input  wire logic         resetn,
    // signal path
    input  wire logic         sigIn,
    input  wire logic [W-1:0] ratio,
    output logic              sigOut
);
    logic         sigPrev_ff;
    logic         sigOut_ff;
    logic [W-1:0] cnt_ff;
    wire          bypass   = (ratio <= W'(1));
    wire          sigRise  = sigIn & ~sigPrev_ff;
    wire          sigFall  = ~sigIn & sigPrev_ff;
    wire          cntWrap  = (cnt_ff >= ratio - W'(1));
    wire [W-1:0]  nxt_cnt  = cntWrap ? '0 : W'(cnt_ff + W'(1));

    assign sigOut = sigOut_ff;

    // output rises on every ratio-th input rise and falls on the following input fall
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            sigPrev_ff <= 1'b0;
            sigOut_ff  <= 1'b0;
            cnt_ff     <= '0;
        end else begin
            sigPrev_ff <= sigIn;
            if (bypass) begin
                sigOut_ff <= sigIn;
                cnt_ff    <= '0;
            end else if (sigRise) begin
                sigOut_ff <= sigOut_ff | (cnt_ff == '0);
                cnt_ff    <= nxt_cnt;
            end else if (sigFall) begin
                sigOut_ff <= 1'b0;
            end
        end
    end
endmodule
`default_nettype wire

// >>> verilog/ptp_stamp_source_and_clkout_ctrl.sv
/*
  ptp control: multicast address-fix enables, divided output clock and the source
  and edge selection of three event timestampers.
  assumes a management front end that presents single-cycle register read and write
  strobes on ref_clk, and timestampers that latch time on the capture pulses.
*/
`timescale 1ns/1ps
`default_nettype none
module ptp_stamp_source_and_clkout_ctrl #(
    parameter int FIRST_RATIO_W = 16
) (
    // clock and reset
    input  wire logic                                ref_clk,
    input  wire logic                                resetn,
    // register access
    input  wire logic                                regWrEn,
    input  wire logic                                regRdEn,
    input  wire logic [ptp_ctrl_pkg::REG_ADDR_W-1:0] regAddr,
    input  wire logic [ptp_ctrl_pkg::REG_DATA_W-1:0] regWrData,
    output logic      [ptp_ctrl_pkg::REG_DATA_W-1:0] regRdData,
    output logic                                     regRdValid,
    // strap for the output clock polarity
    input  wire logic                                clockOutInvertStrap,
    // event sources
    input  wire logic [2:0]                          gpioIn,
    input  wire logic                                ingressSop,
    input  wire logic                                egressSop,
    input  wire logic                                eventGeneratorOneFeedback,
    // address-fix enables to the replacement datapath
    output logic                                     ethMcastDaFixEn,
    output logic                                     peerEthMcastDaFixEn,
    output logic                                     ipPrimaryDaFixEn,
    output logic                                     ipAltADaFixEn,
    output logic                                     ipAltBDaFixEn,
    output logic                                     ipAltCDaFixEn,
    output logic                                     peerIpDaFixEn,
    // output clock pin
    output logic                                     timeClockOutPin,
    // capture pulses to the timestampers
    output logic                                     stamperACapture,
    output logic                                     stamperBCapture,
    output logic                                     stamperCCapture
);
    import ptp_ctrl_pkg::*;

    function automatic logic edgeHit(input logic [1:0] sel, input logic rise, input logic fall);
        edgeHit = ((sel == EDGE_RISE) && rise) || ((sel == EDGE_FALL) && fall)
                || ((sel == EDGE_BOTH) && (rise || fall));
    endfunction

    // source codes 1..3 pick pins 1..3 at vector bits 0..2
    function automatic logic pickPin(input logic [2:0] v, input logic [1:0] src);
        pickPin = (src == SRC_INTERNAL) ? 1'b0 : v[2'(src - 2'h1)];
    endfunction

    logic [FIX_EN_W-1:0]      fixEn_ff;
    logic [CLK_RATIO_W-1:0]   clockOutRatio_ff;
    logic [CLK_RATIO_W-1:0]   ratioSeen_ff;
    logic                     clockOutInvert_ff;
    logic [15:0]              stamperCtrl_ff;
    logic [FIRST_RATIO_W-1:0] firstRatio_ff;
    logic [15:0]              regRdData_ff;
    logic                     regRdValid_ff;
    logic                     strapMeta_ff;
    logic                     strapSync_ff;
    logic [1:0]               strapCnt_ff;
    logic [8:0]               divCnt_ff;
    logic                     clkPhase_ff;
    logic                     clkPin_ff;
    logic [2:0]               gpioMeta_ff;
    logic [2:0]               gpioSync_ff;
    logic [2:0]               gpioPrev_ff;
    logic                     stageTwoPrev_ff;
    logic                     capA_ff;
    logic                     capB_ff;
    logic                     capC_ff;
    logic                     stageOneOut;
    logic                     stageTwoOut;

    // register decode
    wire        wrClockOut   = regWrEn && (regAddr == ADDR_CLOCK_OUT_CTRL);
    wire        wrStamperSrc = regWrEn && (regAddr == ADDR_STAMPER_SRC);
    wire        wrFirstRatio = regWrEn && (regAddr == ADDR_FIRST_RATIO);
    wire [15:0] clockOutWord = {fixEn_ff, clockOutInvert_ff, clockOutRatio_ff};
    wire [15:0] rdMux        = (regAddr == ADDR_CLOCK_OUT_CTRL) ? clockOutWord :
                               (regAddr == ADDR_STAMPER_SRC)    ? stamperCtrl_ff :
                               (regAddr == ADDR_FIRST_RATIO)    ? 16'(firstRatio_ff) : 16'h0000;

    // stamper fields
    wire [1:0]  stamperCEdgeSel     = stamperCtrl_ff[C_EDGE_LSB +: 2];
    wire [1:0]  stamperCSourceField = stamperCtrl_ff[C_SRC_LSB +: 2];
    wire [1:0]  stamperBEdgeSel     = stamperCtrl_ff[B_EDGE_LSB +: 2];
    wire [1:0]  stamperBSourceField = stamperCtrl_ff[B_SRC_LSB +: 2];
    wire [1:0]  stamperAEdgeSel     = stamperCtrl_ff[A_EDGE_LSB +: 2];
    wire [1:0]  stamperASourceSel   = stamperCtrl_ff[A_SRC_LSB +: 2];
    wire [2:0]  stamperASecondCode  = stamperCtrl_ff[A_SECOND_LSB +: 3];
    wire [15:0] stamperASecondRatio = SECOND_RATIO_TABLE[stamperASecondCode];

    assign regRdData           = regRdData_ff;
    assign regRdValid          = regRdValid_ff;
    assign ethMcastDaFixEn     = fixEn_ff[6];
    assign peerEthMcastDaFixEn = fixEn_ff[5];
    assign ipPrimaryDaFixEn    = fixEn_ff[4];
    assign ipAltADaFixEn       = fixEn_ff[3];
    assign ipAltBDaFixEn       = fixEn_ff[2];
    assign ipAltCDaFixEn       = fixEn_ff[1];
    assign peerIpDaFixEn       = fixEn_ff[0];
    assign timeClockOutPin     = clkPin_ff;
    assign stamperACapture     = capA_ff;
    assign stamperBCapture     = capB_ff;
    assign stamperCCapture     = capC_ff;

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            fixEn_ff         <= RESET_CLOCK_OUT[FIX_EN_LSB +: FIX_EN_W];
            clockOutRatio_ff <= RESET_CLOCK_OUT[CLK_RATIO_LSB +: CLK_RATIO_W];
            stamperCtrl_ff   <= RESET_STAMPER_SRC;
            firstRatio_ff    <= RESET_FIRST_RATIO[FIRST_RATIO_W-1:0];
        end else begin
            if (wrClockOut) begin
                fixEn_ff         <= regWrData[FIX_EN_LSB +: FIX_EN_W];
                clockOutRatio_ff <= regWrData[CLK_RATIO_LSB +: CLK_RATIO_W];
            end
            if (wrStamperSrc) begin
                stamperCtrl_ff <= regWrData & STAMPER_SRC_WR_MASK;
            end
            if (wrFirstRatio) begin
                firstRatio_ff <= regWrData[FIRST_RATIO_W-1:0];
            end
        end
    end

    // read data is registered; unmapped addresses read zero
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            regRdData_ff  <= 16'h0000;
            regRdValid_ff <= 1'b0;
        end else begin
            regRdValid_ff <= regRdEn;
            if (regRdEn) begin
                regRdData_ff <= rdMux;
            end
        end
    end

    // invert bit is not bus-writable, so it is taken from a strap once after reset
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            strapMeta_ff      <= 1'b0;
            strapSync_ff      <= 1'b0;
            strapCnt_ff       <= 2'h0;
            clockOutInvert_ff <= RESET_CLOCK_OUT[INVERT_BIT];
        end else begin
            strapMeta_ff <= clockOutInvertStrap;
            strapSync_ff <= strapMeta_ff;
            if (strapCnt_ff != 2'h3) begin
                strapCnt_ff <= 2'(strapCnt_ff + 2'h1);
            end
            if (strapCnt_ff == 2'h2) begin
                clockOutInvert_ff <= strapSync_ff;
            end
        end
    end

    // output clock: one full period is ratio steps of the 125 MHz reference
    wire       clkRestart  = (clockOutRatio_ff != ratioSeen_ff);
    wire       clkOff      = (clockOutRatio_ff == 8'h00);
    wire [8:0] halfTerm    = 9'(9'(clockOutRatio_ff) * 9'(CLKO_HALF_STEP) - 9'h001);
    wire       halfDone    = (divCnt_ff >= halfTerm);

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            ratioSeen_ff <= 8'h00;
            divCnt_ff    <= 9'h000;
            clkPhase_ff  <= 1'b0;
            clkPin_ff    <= 1'b0;
        end else begin
            ratioSeen_ff <= clockOutRatio_ff;
            if (clkRestart || clkOff) begin
                divCnt_ff   <= 9'h000;
                clkPhase_ff <= 1'b0;
            end else if (halfDone) begin
                divCnt_ff   <= 9'h000;
                clkPhase_ff <= ~clkPhase_ff;
            end else begin
                divCnt_ff <= 9'(divCnt_ff + 9'h001);
            end
            clkPin_ff <= clkOff ? 1'b0 : (clkPhase_ff ^ clockOutInvert_ff);
        end
    end

    // pins cross two flops before any edge logic sees them
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            gpioMeta_ff <= 3'h0;
            gpioSync_ff <= 3'h0;
            gpioPrev_ff <= 3'h0;
        end else begin
            gpioMeta_ff <= gpioIn;
            gpioSync_ff <= gpioMeta_ff;
            gpioPrev_ff <= gpioSync_ff;
        end
    end

    wire [2:0] gpioRise = gpioSync_ff & ~gpioPrev_ff;
    wire [2:0] gpioFall = ~gpioSync_ff & gpioPrev_ff;

    // packet-start sources are already one-cycle events, so the edge field has no meaning
    wire nxtCapB = (stamperBSourceField == SRC_INTERNAL) ? egressSop :
                   edgeHit(stamperBEdgeSel, pickPin(gpioRise, stamperBSourceField),
                           pickPin(gpioFall, stamperBSourceField));
    wire nxtCapC = (stamperCSourceField == SRC_INTERNAL) ? ingressSop :
                   edgeHit(stamperCEdgeSel, pickPin(gpioRise, stamperCSourceField),
                           pickPin(gpioFall, stamperCSourceField));
    wire stamperALevel = (stamperASourceSel == SRC_INTERNAL) ? eventGeneratorOneFeedback :
                         pickPin(gpioSync_ff, stamperASourceSel);

    // two cascaded dividers ahead of stamper a
    level_divider #(
        .W      (FIRST_RATIO_W)
    ) u_first_divider (
        .ref_clk(ref_clk),
        .resetn (resetn),
        .sigIn  (stamperALevel),
        .ratio  (firstRatio_ff),
        .sigOut (stageOneOut)
    );

    level_divider #(
        .W      (16)
    ) u_second_divider (
        .ref_clk(ref_clk),
        .resetn (resetn),
        .sigIn  (stageOneOut),
        .ratio  (stamperASecondRatio),
        .sigOut (stageTwoOut)
    );

    wire stageTwoRise = stageTwoOut & ~stageTwoPrev_ff;
    wire stageTwoFall = ~stageTwoOut & stageTwoPrev_ff;

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            stageTwoPrev_ff <= 1'b0;
            capA_ff         <= 1'b0;
            capB_ff         <= 1'b0;
            capC_ff         <= 1'b0;
        end else begin
            stageTwoPrev_ff <= stageTwoOut;
            capA_ff         <= edgeHit(stamperAEdgeSel, stageTwoRise, stageTwoFall);
            capB_ff         <= nxtCapB;
            capC_ff         <= nxtCapC;
        end
    end

    // helper for the half-period check
    logic [8:0] phaseAge_ff;
    wire        phaseFlip = (clkRestart || clkOff || halfDone);
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            phaseAge_ff <= 9'h000;
        end else begin
            phaseAge_ff <= phaseFlip ? 9'h000 : 9'(phaseAge_ff + 9'h001);
        end
    end

    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!resetn);

    sequence s_fix_write;
        wrClockOut;
    endsequence
    sequence s_fix_follow;
        {ethMcastDaFixEn, peerEthMcastDaFixEn, ipPrimaryDaFixEn, ipAltADaFixEn,
         ipAltBDaFixEn, ipAltCDaFixEn, peerIpDaFixEn} == $past(regWrData[15:9]);
    endsequence
    sequence s_b_sop_source;
        (stamperBSourceField == SRC_INTERNAL);
    endsequence

    a_fix_enables: assert property (s_fix_write |=> s_fix_follow)
        else $error("address-fix enables do not follow the written bits");
    a_clock_off: assert property (clkOff |=> !timeClockOutPin)
        else $error("output clock active while ratio is zero");
    a_half_period: assert property (($changed(clkPhase_ff) && $past(!clkRestart)
        && $past(!clkOff)) |-> ($past(phaseAge_ff) == $past(halfTerm)))
        else $error("output clock half period differs from ratio");
    a_pin_polarity: assert property (!clkOff
        |=> timeClockOutPin == ($past(clkPhase_ff) ^ $past(clockOutInvert_ff)))
        else $error("output clock polarity wrong");
    a_ratio_restart: assert property (clkRestart |=> (divCnt_ff == 9'h000) && !clkPhase_ff)
        else $error("divider not restarted on ratio change");
    a_b_sop_only: assert property (s_b_sop_source |=> stamperBCapture == $past(egressSop))
        else $error("stamper b capture not tied to egress packet start");
    a_c_sop_only: assert property ((stamperCSourceField == SRC_INTERNAL)
        |=> stamperCCapture == $past(ingressSop))
        else $error("stamper c capture not tied to ingress packet start");
    a_pin_single_capture: assert property ((stamperCSourceField != SRC_INTERNAL)
        && (stamperCEdgeSel == EDGE_RISE) && $stable(stamperCtrl_ff) && stamperCCapture
        |=> !stamperCCapture)
        else $error("one pin edge captured twice");
    a_edge_none: assert property ((stamperAEdgeSel == EDGE_NONE) |=> !stamperACapture)
        else $error("stamper a captured with edge select none");
    a_first_bypass: assert property ((firstRatio_ff <= FIRST_RATIO_W'(1))
        |=> stageOneOut == $past(stamperALevel))
        else $error("first divider not bypassed for ratio zero or one");
    // a restart must begin on the inactive level, never with a shortened half period
    sequence s_restart_run;
        (clkRestart && !clkOff) ##1 !clkOff;
    endsequence
    a_restart_level: assert property (s_restart_run
        |=> timeClockOutPin == $past(clockOutInvert_ff))
        else $error("output clock did not restart on its inactive level");
    a_invert_hold: assert property ((strapCnt_ff == 2'h3)
        |=> $stable(clockOutInvert_ff))
        else $error("read-only invert bit changed after start-up");
    a_b_edge_none: assert property ((stamperBSourceField != SRC_INTERNAL)
        && (stamperBEdgeSel == EDGE_NONE) |=> !stamperBCapture)
        else $error("stamper b captured a pin with edge select none");
    a_c_edge_none: assert property ((stamperCSourceField != SRC_INTERNAL)
        && (stamperCEdgeSel == EDGE_NONE) |=> !stamperCCapture)
        else $error("stamper c captured a pin with edge select none");
endmodule
`default_nettype wire

// >>> verification/gpio_source_model.sv
/*
  model of the external timing sources on the three general-purpose pins.
  assumes the caller starts each pulse away from a rising ref_clk edge; the pins are
  asynchronous to the device, and each level is held well beyond two clock cycles.
*/
`timescale 1ns/1ps
`default_nettype none
module gpio_source_model (
    // pins toward the device
    output var logic [2:0] gpioOut
);
    initial begin
        gpioOut = 3'h0;
    end
    // one high then one low level on a pin, each held for holdNs
    task automatic pulse(input int pin, input int holdNs);
        gpioOut[pin] = 1'b1;
        #(holdNs);
        gpioOut[pin] = 1'b0;
        #(holdNs);
    endtask
endmodule
`default_nettype wire

// >>> verification/ptp_stamp_source_and_clkout_ctrl_tb.sv
/*
  self-checking bench for the ptp address-fix, output clock and stamper source block.
  assumes the register strobe protocol of the block and a 250 MHz ref_clk.
*/
`timescale 1ns/1ps
`default_nettype none
module ptp_stamp_source_and_clkout_ctrl_tb;
    import ptp_ctrl_pkg::*;
    logic        ref_clk = 1'b0;
    logic        resetn = 1'b0;
    logic        regWrEn = 1'b0;
    logic        regRdEn = 1'b0;
    logic [4:0]  regAddr = 5'h00;
    logic [15:0] regWrData = 16'h0000;
    logic [15:0] regRdData;
    logic        regRdValid;
    logic [2:0]  gpioIn;
    logic        ingressSop = 1'b0;
    logic        egressSop = 1'b0;
    logic        feedback = 1'b0;
    logic        strap = 1'b0;
    wire  [6:0]  fixV;
    logic        pin;
    logic        capA, capB, capC;
    int          nCapA, nCapB, nCapC, nFail, nChecks, run;
    always #2 ref_clk = ~ref_clk;
    gpio_source_model u_gpio_source_model (.gpioOut(gpioIn));
    ptp_stamp_source_and_clkout_ctrl #(.FIRST_RATIO_W(16)) u_ptp_stamp_source_and_clkout_ctrl (
        .ref_clk(ref_clk), .resetn(resetn), .regWrEn(regWrEn), .regRdEn(regRdEn),
        .regAddr(regAddr), .regWrData(regWrData), .regRdData(regRdData),
        .regRdValid(regRdValid), .clockOutInvertStrap(strap), .gpioIn(gpioIn),
        .ingressSop(ingressSop), .egressSop(egressSop), .eventGeneratorOneFeedback(feedback),
        .ethMcastDaFixEn(fixV[6]), .peerEthMcastDaFixEn(fixV[5]), .ipPrimaryDaFixEn(fixV[4]),
        .ipAltADaFixEn(fixV[3]), .ipAltBDaFixEn(fixV[2]), .ipAltCDaFixEn(fixV[1]),
        .peerIpDaFixEn(fixV[0]), .timeClockOutPin(pin), .stamperACapture(capA),
        .stamperBCapture(capB), .stamperCCapture(capC));
    // pin and divider capture pulses are one cycle wide, so counting per edge counts events; a packet-start capture lasts as long as its input
    always @(posedge ref_clk) begin
        if (capA === 1'b1) nCapA++;
        if (capB === 1'b1) nCapB++;
        if (capC === 1'b1) nCapC++;
    end
    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
        nChecks++;
        if (got !== exp) begin
            nFail++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic regWrite(input logic [4:0] a, input logic [15:0] d);
        @(posedge ref_clk);
        regWrEn <= 1'b1;
        regAddr <= a;
        regWrData <= d;
        @(posedge ref_clk);
        regWrEn <= 1'b0;
    endtask
    task automatic regRead(input logic [4:0] a, input logic [15:0] exp);
        @(posedge ref_clk);
        regRdEn <= 1'b1;
        regAddr <= a;
        @(posedge ref_clk);
        regRdEn <= 1'b0;
        @(negedge ref_clk);
        check("read valid", 16'h0001, {15'h0, regRdValid});
        check("read data", exp, regRdData);
    endtask
    task automatic clearCounts();
        @(negedge ref_clk);
        nCapA = 0;
        nCapB = 0;
        nCapC = 0;
    endtask
    task automatic summarize();
        $display("checks %0d mismatches %0d", nChecks, nFail);
        if (nFail == 0 && nChecks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge ref_clk);
        nFail++;
        summarize();
    end
    initial begin
        repeat (2) @(posedge ref_clk);
        resetn <= 1'b1;
        repeat (4) @(posedge ref_clk);
        regRead(ADDR_CLOCK_OUT_CTRL, RESET_CLOCK_OUT);
        regRead(ADDR_STAMPER_SRC, RESET_STAMPER_SRC);
        regRead(ADDR_FIRST_RATIO, RESET_FIRST_RATIO);
        regRead(5'h13, 16'h0000);
        regWrite(ADDR_STAMPER_SRC, 16'hffff);
        regRead(ADDR_STAMPER_SRC, 16'hfff7);
        regWrite(ADDR_CLOCK_OUT_CTRL, 16'hff00);
        regRead(ADDR_CLOCK_OUT_CTRL, 16'hfe00);
        // one enable at a time, so a swapped output shows up
        for (int i = 0; i < 7; i++) begin
            regWrite(ADDR_CLOCK_OUT_CTRL, 16'h0200 << i);
            @(negedge ref_clk);
            check("fix enables", 16'h0001 << i, {9'h0, fixV});
        end
        regWrite(ADDR_CLOCK_OUT_CTRL, 16'h0003);
        repeat (12) @(negedge ref_clk);
        while (pin !== 1'b0) @(negedge ref_clk);
        while (pin !== 1'b1) @(negedge ref_clk);
        for (int lvl = 1; lvl >= 0; lvl--) begin
            run = 0;
            while (pin === lvl[0] && run < 50) begin
                run++;
                @(negedge ref_clk);
            end
            check("clock out level run", 16'h0003, run[15:0]);
        end
        regWrite(ADDR_CLOCK_OUT_CTRL, 16'h0000);
        repeat (3) @(negedge ref_clk);
        run = 0;
        repeat (20) begin
            @(negedge ref_clk);
            if (pin !== 1'b0) run++;
        end
        check("clock out disabled", 16'h0000, run[15:0]);
        // b watches pin two and c pin three, so each pulse must hit only its own stamper
        for (int code = 0; code < 4; code++) begin
            regWrite(ADDR_STAMPER_SRC, 16'(32'h3200 | (code << 14) | (code << 10)));
            clearCounts();
            // 20 ns levels keep every pin change on a falling clock edge
            u_gpio_source_model.pulse(1, 20);
            u_gpio_source_model.pulse(2, 20);
            repeat (8) @(negedge ref_clk);
            check("stamper b pin captures", {15'h0, code[0]} + {15'h0, code[1]}, nCapB[15:0]);
            check("stamper c pin captures", {15'h0, code[0]} + {15'h0, code[1]}, nCapC[15:0]);
        end
        regWrite(ADDR_STAMPER_SRC, 16'h0000);
        clearCounts();
        @(posedge ref_clk);
        egressSop <= 1'b1;
        ingressSop <= 1'b1;
        @(posedge ref_clk);
        ingressSop <= 1'b0;
        @(posedge ref_clk);
        egressSop <= 1'b0;
        repeat (4) @(negedge ref_clk);
        check("stamper b sop captures", 16'h0002, nCapB[15:0]);
        check("stamper c sop captures", 16'h0001, nCapC[15:0]);
        regWrite(ADDR_FIRST_RATIO, 16'h0003);
        regWrite(ADDR_STAMPER_SRC, 16'h0044);
        clearCounts();
        // twelve feedback rises through divide by 3 then by 2 leave two rises
        repeat (12) begin
            @(posedge ref_clk);
            feedback <= 1'b1;
            repeat (3) @(posedge ref_clk);
            feedback <= 1'b0;
            repeat (3) @(posedge ref_clk);
        end
        repeat (8) @(negedge ref_clk);
        check("stamper a divided captures", 16'h0002, nCapA[15:0]);
        // pin one on stamper a, both edges, both dividers bypassed
        regWrite(ADDR_FIRST_RATIO, 16'h0001);
        regWrite(ADDR_STAMPER_SRC, 16'h00d0);
        clearCounts();
        u_gpio_source_model.pulse(0, 20);
        repeat (8) @(negedge ref_clk);
        check("stamper a pin captures", 16'h0002, nCapA[15:0]);
        // second reset with the strap high: invert comes up set, everything else cleared
        @(posedge ref_clk);
        strap <= 1'b1;
        resetn <= 1'b0;
        repeat (2) @(posedge ref_clk);
        resetn <= 1'b1;
        repeat (4) @(posedge ref_clk);
        regRead(ADDR_CLOCK_OUT_CTRL, 16'h0100);
        regRead(ADDR_STAMPER_SRC, RESET_STAMPER_SRC);
        regRead(ADDR_FIRST_RATIO, RESET_FIRST_RATIO);
        regWrite(ADDR_CLOCK_OUT_CTRL, 16'h0004);
        repeat (3) @(negedge ref_clk);
        check("clock out inverted", 16'h0001, {15'h0, pin});
        regWrite(ADDR_CLOCK_OUT_CTRL, 16'h0000);
        repeat (3) @(negedge ref_clk);
        check("clock out off inverted", 16'h0000, {15'h0, pin});
        summarize();
    end
endmodule
`default_nettype wire
